// file: rtl/pfsb_bank.sv
// Fault limits, response selectors and status registers of the rectifier management interface.
`timescale 1ns/100ps
`include "pfsb_params.svh"
// Contract
// (R1) Output above overvoltage warning threshold (default 13.8 V) raises the alert.
// (R2) Output below undervoltage warning threshold (default 10.8 V) raises the alert.
// (R3) Output below undervoltage fault threshold shuts down, masked during input dropout.
// (R4) Output undervoltage selector takes only 0x80 latch or 0xC0 restart, default restart.
// (R5) Overcurrent threshold applies at high line; low line uses fixed 45 A.
// (R6) Overcurrent selector defaults to hiccup 0xF8, else latched 0xC0, both lines.
// (R7) Overcurrent warning: programmable at high line, fixed 62.5 A at low line.
// (R8) Temperature compared to fault and warning thresholds; fault triggers its response.
// (R9) Temperature selector defaults to hiccup 0xC0, else latched 0x80.
// (R10) Input above overvoltage threshold (default 275 V) shuts down; writes only lower it.
// (R11) Input over- and undervoltage selectors take only 0x80 or 0xC0, default restart.
// (R12) Input undervoltage warning (default 87.5 V); writes may only raise it.
// (R13) Input below undervoltage fault threshold (default 80 V) shuts down; only raised.
// (R14) Input undervoltage response follows its own selector only.
// (R15) Summary byte: busy, off, vout OV, iout OC, vin UV, temp, comm, none.
// (R16) Status word: summary low byte; high byte carries category flags.
// (R17) Output voltage byte: OV fault, OV warn, UV warn, UV fault; low nibble zero.
// (R18) Output current byte: OC fault, LV OC fault, warn, share fault, power limiting.
// (R19) Overcurrent threshold is the limit; shutdown only when output below LV setting.
// (R20) Input byte: OV fault, OV warn, UV warn, UV fault, low-input off, input OC.
// (R21) Temperature byte: fault bit 7, warning bit 6, rest zero.
// (R22) Comm byte: bad command, bad data, packet check failure, other fault.
// (R23) Clear-faults from controlling side clears all flags and the alert.
// (R24) A fault that persists after clear-faults sets its flag again.
// (R25) Flags stay set until clear-faults or successful restart.
// (R26) Bad selector writes are rejected and set the invalid-data flag.
module pfsb_bank import pfsb_pkg::*; #(
	parameter logic [15:0] OC_LV_LEVEL = `PFSB_DEF_OC_LV
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Command port from the bus front end
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic cmd_in_control_i,
	output logic [15:0] cmd_rdata_o,
	output logic cmd_rvalid_o,
	// Measurements and hardware status
	input wire pfsb_meas_s meas_i,
	input wire pfsb_hw_s hw_i,
	input wire logic restart_done_i,
	// Alert and power control
	output logic smb_alert_o,
	output logic output_off_o,
	output logic latched_off_o
);
	localparam logic [9:0][15:0] THR_RESET = {`PFSB_DEF_VI_UVF, `PFSB_DEF_VI_UVW, `PFSB_DEF_VI_OVF,
		`PFSB_DEF_HOTW, `PFSB_DEF_HOTF, `PFSB_DEF_OCW, `PFSB_DEF_OCF,
		`PFSB_DEF_VO_UVF, `PFSB_DEF_VO_UVW, `PFSB_DEF_VO_OVW};
	localparam logic [4:0][7:0] ACT_RESET = {`PFSB_ACT_C0, `PFSB_ACT_C0, `PFSB_ACT_C0,
		`PFSB_ACT_F8, `PFSB_ACT_C0};

	logic [9:0][15:0] thr_q;
	logic [4:0][7:0] act_q;
	logic [4:0] latch_q;
	logic [4:0] latch_mode;
	pfsb_flags_s flags_q;
	pfsb_flags_s flag_set;

	function automatic logic [3:0] thr_idx(input logic [7:0] c);
		if (c == `PFSB_CMD_VO_OVW) thr_idx = `PFSB_TI_VO_OVW;
		else if (c == `PFSB_CMD_VO_UVW) thr_idx = `PFSB_TI_VO_UVW;
		else if (c == `PFSB_CMD_VO_UVF) thr_idx = `PFSB_TI_VO_UVF;
		else if (c == `PFSB_CMD_OCF) thr_idx = `PFSB_TI_OCF;
		else if (c == `PFSB_CMD_OCW) thr_idx = `PFSB_TI_OCW;
		else if (c == `PFSB_CMD_HOTF) thr_idx = `PFSB_TI_HOTF;
		else if (c == `PFSB_CMD_HOTW) thr_idx = `PFSB_TI_HOTW;
		else if (c == `PFSB_CMD_VI_OVF) thr_idx = `PFSB_TI_VI_OVF;
		else if (c == `PFSB_CMD_VI_UVW) thr_idx = `PFSB_TI_VI_UVW;
		else if (c == `PFSB_CMD_VI_UVF) thr_idx = `PFSB_TI_VI_UVF;
		else thr_idx = `PFSB_TI_NONE;
	endfunction

	function automatic logic [2:0] act_idx(input logic [7:0] c);
		if (c == `PFSB_CMD_VO_UVA) act_idx = `PFSB_AI_VO_UV;
		else if (c == `PFSB_CMD_OCA) act_idx = `PFSB_AI_OC;
		else if (c == `PFSB_CMD_HOTA) act_idx = `PFSB_AI_HOT;
		else if (c == `PFSB_CMD_VI_OVA) act_idx = `PFSB_AI_VI_OV;
		else if (c == `PFSB_CMD_VI_UVA) act_idx = `PFSB_AI_VI_UV;
		else act_idx = `PFSB_AI_NONE;
	endfunction

	// Only two encodings exist per selector; overcurrent uses a different pair.
	function automatic logic act_ok(input logic [2:0] i, input logic [7:0] v);
		if (i == `PFSB_AI_OC) act_ok = (v == `PFSB_ACT_F8) || (v == `PFSB_ACT_C0); // R6
		else act_ok = (v == `PFSB_ACT_80) || (v == `PFSB_ACT_C0); // R4 R9 R11
	endfunction

	function automatic logic act_latch(input logic [2:0] i, input logic [7:0] v);
		if (i == `PFSB_AI_OC) act_latch = (v == `PFSB_ACT_C0); // R6
		else act_latch = (v == `PFSB_ACT_80); // R4 R9 R11
	endfunction

	// Input limits may only move toward safer operation.
	function automatic logic thr_ok(input logic [3:0] i, input logic [15:0] old, input logic [15:0] nw);
		if (i == `PFSB_TI_VI_OVF) thr_ok = nw <= old; // R10
		else if (i == `PFSB_TI_VI_UVW || i == `PFSB_TI_VI_UVF) thr_ok = nw >= old; // R12 R13
		else thr_ok = 1'b1;
	endfunction

	// Command decode.
	wire logic [3:0] ti = thr_idx(cmd_code_i);
	wire logic [2:0] ai = act_idx(cmd_code_i);
	wire logic is_thr = ti != `PFSB_TI_NONE;
	wire logic is_act = ai != `PFSB_AI_NONE;
	wire logic is_clear = cmd_code_i == `PFSB_CMD_CLEAR;
	// A clear from the side not in control is ignored silently.
	wire logic clear_cmd = cmd_wr_i && is_clear && cmd_in_control_i; // R23
	wire logic clear_all = clear_cmd || restart_done_i; // R25
	wire logic thr_good = thr_ok(ti, thr_q[ti], cmd_wdata_i);
	wire logic act_good = act_ok(ai, cmd_wdata_i[7:0]);
	wire logic thr_wr = cmd_wr_i && is_thr && thr_good;
	wire logic act_wr = cmd_wr_i && is_act && act_good;
	wire logic bad_data = cmd_wr_i && ((is_thr && !thr_good) || (is_act && !act_good)); // R26
	wire logic wr_unknown = cmd_wr_i && !is_thr && !is_act && !is_clear;
	wire logic is_stat = cmd_code_i == `PFSB_CMD_ST_BYTE || cmd_code_i == `PFSB_CMD_ST_WORD
		|| cmd_code_i == `PFSB_CMD_ST_VOUT || cmd_code_i == `PFSB_CMD_ST_IOUT
		|| cmd_code_i == `PFSB_CMD_ST_IN || cmd_code_i == `PFSB_CMD_ST_TEMP
		|| cmd_code_i == `PFSB_CMD_ST_COMM || cmd_code_i == `PFSB_CMD_ST_FAN;
	wire logic rd_unknown = cmd_rd_i && !is_thr && !is_act && !is_stat;

	// Threshold comparisons.
	wire logic vo_ovw_c = meas_i.vout > thr_q[`PFSB_TI_VO_OVW]; // R1
	wire logic vo_uvw_c = meas_i.vout < thr_q[`PFSB_TI_VO_UVW]; // R2
	wire logic vo_uvf_c = (meas_i.vout < thr_q[`PFSB_TI_VO_UVF]) && !hw_i.vin_dropout; // R3
	wire logic [15:0] oc_lim = hw_i.high_line ? thr_q[`PFSB_TI_OCF] : `PFSB_LL_OCF; // R5
	wire logic [15:0] ocw_lim = hw_i.high_line ? thr_q[`PFSB_TI_OCW] : `PFSB_LL_OCW; // R7
	wire logic oc_c = meas_i.iout > oc_lim; // R19
	// Past the limit the output folds back; the shutdown waits for the low-voltage point.
	wire logic oc_lv_c = oc_c && (meas_i.vout < OC_LV_LEVEL); // R19
	wire logic ocw_c = meas_i.iout > ocw_lim; // R7
	wire logic hotf_c = meas_i.temp > thr_q[`PFSB_TI_HOTF]; // R8
	wire logic hotw_c = meas_i.temp > thr_q[`PFSB_TI_HOTW]; // R8
	wire logic vi_ov_c = meas_i.vin > thr_q[`PFSB_TI_VI_OVF]; // R10
	wire logic vi_uvw_c = meas_i.vin < thr_q[`PFSB_TI_VI_UVW]; // R12
	wire logic vi_uvf_c = meas_i.vin < thr_q[`PFSB_TI_VI_UVF]; // R13

	// Trip vector lines up with the selector indices.
	wire logic [4:0] trip = {vi_uvf_c, vi_ov_c, hotf_c, oc_lv_c, vo_uvf_c};
	wire logic [4:0] next_latch = restart_done_i ? 5'h00 : (latch_q | (trip & latch_mode));
	wire logic next_off = |(trip | latch_q);

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			latch_mode[i] = act_latch(3'(i), act_q[i]); // R14
		end
	end

	always_comb begin
		flag_set = '0;
		flag_set.vout_ov_f = hw_i.vout_ov_fault;
		flag_set.vout_ov_w = vo_ovw_c; // R1
		flag_set.vout_uv_w = vo_uvw_c; // R2
		flag_set.vout_uv_f = vo_uvf_c; // R3
		flag_set.oc_f = oc_c; // R5
		flag_set.oc_lv_f = oc_lv_c; // R19
		flag_set.oc_w = ocw_c; // R7
		flag_set.share_f = hw_i.share_fault;
		flag_set.plim = hw_i.power_limit;
		flag_set.vin_ov_f = vi_ov_c; // R10
		flag_set.vin_ov_w = hw_i.vin_ov_warn;
		flag_set.vin_uv_w = vi_uvw_c; // R12
		flag_set.vin_uv_f = vi_uvf_c; // R13
		flag_set.low_in_off = vi_uvf_c; // R20
		flag_set.iin_oc_f = hw_i.iin_oc_fault;
		flag_set.hot_f = hotf_c; // R8
		flag_set.hot_w = hotw_c; // R8
		flag_set.bad_cmd = wr_unknown || rd_unknown; // R22
		flag_set.bad_data = bad_data; // R26
		flag_set.pec_f = hw_i.pec_error; // R22
		flag_set.other_comm = hw_i.comm_fault; // R22
		flag_set.fan_f = hw_i.fan_fault;
		flag_set.fan_ovr = hw_i.fan_override;
	end

	// Conditions are fed every cycle, so a flag cleared while its fault lasts sets again next cycle.
	pfsb_sticky #(
		.WIDTH($bits(pfsb_flags_s))
	) u_flags (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clr_i(clear_all), // R24
		.set_i(flag_set),
		.q_o(flags_q)
	);

	// Status bytes.
	wire logic [7:0] st_vout = {flags_q.vout_ov_f, flags_q.vout_ov_w, flags_q.vout_uv_w,
		flags_q.vout_uv_f, 4'h0}; // R17
	wire logic [7:0] st_iout = {flags_q.oc_lv_f | flags_q.oc_f, flags_q.oc_lv_f, flags_q.oc_w, 1'b0,
		flags_q.share_f, flags_q.plim, 2'h0}; // R18
	wire logic [7:0] st_in = {flags_q.vin_ov_f, flags_q.vin_ov_w, flags_q.vin_uv_w, flags_q.vin_uv_f,
		flags_q.low_in_off, flags_q.iin_oc_f, 2'h0}; // R20
	wire logic [7:0] st_temp = {flags_q.hot_f, flags_q.hot_w, 6'h00}; // R21
	wire logic [7:0] st_comm = {flags_q.bad_cmd, flags_q.bad_data, flags_q.pec_f, 3'h0,
		flags_q.other_comm, 1'b0}; // R22
	wire logic [7:0] st_fan = {flags_q.fan_f, 3'h0, {2{flags_q.fan_ovr}}, 2'h0};
	wire logic [7:0] word_hi = {|st_vout, |st_iout, |st_in, hw_i.mfr_fault, hw_i.pgood_n,
		|st_fan, 2'h0}; // R16
	wire logic [6:0] byte_hi = {hw_i.busy, output_off_o, flags_q.vout_ov_f, st_iout[7],
		flags_q.vin_uv_f, |st_temp, |st_comm}; // R15
	// The last bit is set when the high byte shows something and none of the seven bits above is set.
	wire logic [7:0] st_byte = {byte_hi, !(|byte_hi) && (|word_hi)}; // R15

	// Read selection.
	wire logic [15:0] rd_val = is_thr ? thr_q[ti]
		: is_act ? {8'h00, act_q[ai]}
		: cmd_code_i == `PFSB_CMD_ST_BYTE ? {8'h00, st_byte}
		: cmd_code_i == `PFSB_CMD_ST_WORD ? {word_hi, st_byte} // R16
		: cmd_code_i == `PFSB_CMD_ST_VOUT ? {8'h00, st_vout}
		: cmd_code_i == `PFSB_CMD_ST_IOUT ? {8'h00, st_iout}
		: cmd_code_i == `PFSB_CMD_ST_IN ? {8'h00, st_in}
		: cmd_code_i == `PFSB_CMD_ST_TEMP ? {8'h00, st_temp}
		: cmd_code_i == `PFSB_CMD_ST_COMM ? {8'h00, st_comm}
		: cmd_code_i == `PFSB_CMD_ST_FAN ? {8'h00, st_fan}
		: 16'h0000;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			thr_q <= THR_RESET;
			act_q <= ACT_RESET;
		end else begin
			if (thr_wr) begin
				thr_q[ti] <= cmd_wdata_i; // R10 R12 R13
			end
			if (act_wr) begin
				act_q[ai] <= cmd_wdata_i[7:0]; // R26
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			latch_q <= 5'h00;
			output_off_o <= 1'b0;
			latched_off_o <= 1'b0;
			smb_alert_o <= 1'b0;
		end else begin
			latch_q <= next_latch; // R14
			output_off_o <= next_off; // R3 R8 R10 R13 R19
			latched_off_o <= |next_latch;
			smb_alert_o <= |flags_q; // R1 R2 R23
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_rdata_o <= 16'h0000;
			cmd_rvalid_o <= 1'b0;
		end else begin
			cmd_rvalid_o <= cmd_rd_i;
			if (cmd_rd_i) begin
				cmd_rdata_o <= rd_val;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_clear;
		clear_cmd;
	endsequence
	sequence s_bad_act_wr;
		cmd_wr_i && is_act && !act_ok(ai, cmd_wdata_i[7:0]) && !restart_done_i;
	endsequence

	property p_ovw_alert;
		(meas_i.vout > thr_q[`PFSB_TI_VO_OVW] && !clear_all) |-> ##2 smb_alert_o;
	endproperty
	a_ovw_alert: assert property (p_ovw_alert) else $error("no alert on output overvoltage warning"); // R1

	property p_uvw_flag;
		(meas_i.vout < thr_q[`PFSB_TI_VO_UVW] && !clear_all) |=> flags_q.vout_uv_w ##1 smb_alert_o;
	endproperty
	a_uvw_flag: assert property (p_uvw_flag) else $error("undervoltage warning not flagged"); // R2

	property p_uv_mask;
		$rose(flags_q.vout_uv_f) |-> $past(!hw_i.vin_dropout);
	endproperty
	a_uv_mask: assert property (p_uv_mask) else $error("undervoltage fault during input dropout"); // R3

	property p_ll_oc;
		(!hw_i.high_line && meas_i.iout > `PFSB_LL_OCF && meas_i.vout < OC_LV_LEVEL) |=> output_off_o;
	endproperty
	a_ll_oc: assert property (p_ll_oc) else $error("low line overcurrent did not shut down"); // R5

	property p_hot_off;
		(meas_i.temp > thr_q[`PFSB_TI_HOTF]) |=> output_off_o;
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("overtemperature did not shut down"); // R8

	property p_vin_ov_lower;
		(cmd_wr_i && ti == `PFSB_TI_VI_OVF && cmd_wdata_i > thr_q[`PFSB_TI_VI_OVF]) |=> $stable(thr_q);
	endproperty
	a_vin_ov_lower: assert property (p_vin_ov_lower) else $error("input overvoltage limit raised"); // R10

	property p_vin_uv_raise;
		(cmd_wr_i && (ti == `PFSB_TI_VI_UVW || ti == `PFSB_TI_VI_UVF) && cmd_wdata_i < thr_q[ti] && !restart_done_i)
			|=> $stable(thr_q) && flags_q.bad_data;
	endproperty
	a_vin_uv_raise: assert property (p_vin_uv_raise) else $error("input undervoltage limit lowered"); // R13

	property p_clear;
		s_clear |=> flags_q == '0 ##1 !smb_alert_o;
	endproperty
	a_clear: assert property (p_clear) else $error("clear faults left flags or alert set"); // R23

	property p_reflag;
		s_clear ##1 (meas_i.temp > thr_q[`PFSB_TI_HOTW] && !clear_all) |=> flags_q.hot_w;
	endproperty
	a_reflag: assert property (p_reflag) else $error("persisting warning not set again"); // R24

	property p_act_reject;
		s_bad_act_wr |=> $stable(act_q) && flags_q.bad_data;
	endproperty
	a_act_reject: assert property (p_act_reject) else $error("bad selector write was taken"); // R26

	property p_ll_ocw;
		(!hw_i.high_line && meas_i.iout > `PFSB_LL_OCW && !clear_all) |=> flags_q.oc_w;
	endproperty
	a_ll_ocw: assert property (p_ll_ocw) else $error("low line overcurrent warning not flagged"); // R7

	property p_hot_warn;
		(meas_i.temp > thr_q[`PFSB_TI_HOTW] && !clear_all) |=> flags_q.hot_w;
	endproperty
	a_hot_warn: assert property (p_hot_warn) else $error("overtemperature warning not flagged"); // R8

	property p_off_latched;
		latched_off_o |-> output_off_o;
	endproperty
	a_off_latched: assert property (p_off_latched) else $error("latched response left output on"); // R9

	property p_vi_uv_latch;
		(meas_i.vin < thr_q[`PFSB_TI_VI_UVF] && act_q[`PFSB_AI_VI_UV] == `PFSB_ACT_80 && !restart_done_i)
			|=> latched_off_o;
	endproperty
	a_vi_uv_latch: assert property (p_vi_uv_latch) else $error("input undervoltage latch not held"); // R14
endmodule

// file: rtl/pfsb_params.svh
// Command codes, table indices, encodings and reset values of the fault limit and status bank.
`ifndef PFSB_PARAMS_SVH
`define PFSB_PARAMS_SVH
`define PFSB_CMD_CLEAR 8'h03
`define PFSB_CMD_VO_OVW 8'h42
`define PFSB_CMD_VO_UVW 8'h43
`define PFSB_CMD_VO_UVF 8'h44
`define PFSB_CMD_VO_UVA 8'h45
`define PFSB_CMD_OCF 8'h46
`define PFSB_CMD_OCA 8'h47
`define PFSB_CMD_OCW 8'h4A
`define PFSB_CMD_HOTF 8'h4F
`define PFSB_CMD_HOTA 8'h50
`define PFSB_CMD_HOTW 8'h51
`define PFSB_CMD_VI_OVF 8'h55
`define PFSB_CMD_VI_OVA 8'h56
`define PFSB_CMD_VI_UVW 8'h58
`define PFSB_CMD_VI_UVF 8'h59
`define PFSB_CMD_VI_UVA 8'h5A
`define PFSB_CMD_ST_BYTE 8'h78
`define PFSB_CMD_ST_WORD 8'h79
`define PFSB_CMD_ST_VOUT 8'h7A
`define PFSB_CMD_ST_IOUT 8'h7B
`define PFSB_CMD_ST_IN 8'h7C
`define PFSB_CMD_ST_TEMP 8'h7D
`define PFSB_CMD_ST_COMM 8'h7E
`define PFSB_CMD_ST_FAN 8'h81
// Threshold table indices.
`define PFSB_TI_VO_OVW 4'h0
`define PFSB_TI_VO_UVW 4'h1
`define PFSB_TI_VO_UVF 4'h2
`define PFSB_TI_OCF 4'h3
`define PFSB_TI_OCW 4'h4
`define PFSB_TI_HOTF 4'h5
`define PFSB_TI_HOTW 4'h6
`define PFSB_TI_VI_OVF 4'h7
`define PFSB_TI_VI_UVW 4'h8
`define PFSB_TI_VI_UVF 4'h9
`define PFSB_TI_NONE 4'hF
// Response selector indices.
`define PFSB_AI_VO_UV 3'h0
`define PFSB_AI_OC 3'h1
`define PFSB_AI_HOT 3'h2
`define PFSB_AI_VI_OV 3'h3
`define PFSB_AI_VI_UV 3'h4
`define PFSB_AI_NONE 3'h7
// Response encodings.
`define PFSB_ACT_80 8'h80
`define PFSB_ACT_C0 8'hC0
`define PFSB_ACT_F8 8'hF8
// Reset values; voltages in mV (output) or 0.1 V (input), currents in 0.1 A, temperature in 0.1 C.
`define PFSB_DEF_VO_OVW 16'h35E8
`define PFSB_DEF_VO_UVW 16'h2A30
`define PFSB_DEF_VO_UVF 16'h2710
`define PFSB_DEF_OCF 16'h0294
`define PFSB_DEF_OCW 16'h0258
`define PFSB_DEF_HOTF 16'h0384
`define PFSB_DEF_HOTW 16'h0320
`define PFSB_DEF_VI_OVF 16'h0ABE
`define PFSB_DEF_VI_UVW 16'h036B
`define PFSB_DEF_VI_UVF 16'h0320
`define PFSB_LL_OCF 16'h01C2
`define PFSB_LL_OCW 16'h0271
`define PFSB_DEF_OC_LV 16'h2328
`endif

// file: rtl/pfsb_pkg.sv
// Types shared by the fault limit and status bank.
package pfsb_pkg;
	typedef struct packed {
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] vin;
		logic [15:0] temp;
	} pfsb_meas_s;
	typedef struct packed {
		logic high_line;
		logic vin_dropout;
		logic busy;
		logic vout_ov_fault;
		logic vin_ov_warn;
		logic iin_oc_fault;
		logic share_fault;
		logic power_limit;
		logic fan_fault;
		logic fan_override;
		logic pgood_n;
		logic mfr_fault;
		logic pec_error;
		logic comm_fault;
	} pfsb_hw_s;
	typedef struct packed {
		logic vout_ov_f, vout_ov_w, vout_uv_w, vout_uv_f;
		logic oc_f, oc_lv_f, oc_w, share_f, plim;
		logic vin_ov_f, vin_ov_w, vin_uv_w, vin_uv_f, low_in_off, iin_oc_f;
		logic hot_f, hot_w;
		logic bad_cmd, bad_data, pec_f, other_comm;
		logic fan_f, fan_ovr;
	} pfsb_flags_s;
endpackage

// file: rtl/pfsb_sticky.sv
// Sticky flag vector: bits set on their condition and hold until cleared.
`timescale 1ns/100ps
module pfsb_sticky #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Set and clear
	input wire logic clr_i,
	input wire logic [WIDTH-1:0] set_i,
	// Flags
	output logic [WIDTH-1:0] q_o
);
	// The clear wins for one cycle so that a persisting condition visibly drops and sets again.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_o <= '0;
		end else if (clr_i) begin
			q_o <= '0;
		end else begin
			q_o <= q_o | set_i; // R25
		end
	end

	property p_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		!clr_i |=> ((q_o & $past(q_o)) == $past(q_o));
	endproperty
	a_hold: assert property (p_hold) else $error("sticky flag dropped without clear"); // R25
endmodule

// file: verification/pfsb_host.sv
// Host model that issues reads, writes and clear-faults to the bank's command port.
`timescale 1ns/100ps
module pfsb_host (
	// Clock
	input wire logic clk_i,
	// Command port towards the bank
	output logic cmd_wr_o,
	output logic cmd_rd_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_wdata_o,
	output logic cmd_in_control_o,
	input wire logic [15:0] cmd_rdata_i,
	input wire logic cmd_rvalid_i
);
	int gap = 0;
	initial begin
		cmd_wr_o = 1'b0;
		cmd_rd_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
		cmd_in_control_o = 1'b1;
	end
	// The code line is inverted after every request and the data line after writes, so stale values never look valid.
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ctl);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		cmd_wr_o <= 1'b1;
		cmd_code_o <= c;
		cmd_wdata_o <= d;
		cmd_in_control_o <= ctl;
		@(posedge clk_i);
		cmd_wr_o <= 1'b0;
		cmd_code_o <= ~c;
		cmd_wdata_o <= ~d;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		cmd_rd_o <= 1'b1;
		cmd_code_o <= c;
		@(posedge clk_i);
		cmd_rd_o <= 1'b0;
		cmd_code_o <= ~c;
		#1;
		d = cmd_rdata_i;
		v = cmd_rvalid_i;
	endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench of the fault limit and status bank, driven through the host model.
`timescale 1ns/100ps
`include "pfsb_params.svh"
module testbench import pfsb_pkg::*; ;
	localparam pfsb_meas_s NOM = 64'h2EE0_0100_08FC_0200;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic restart_done = 1'b0;
	pfsb_meas_s meas;
	pfsb_hw_s hw;
	logic cmd_wr, cmd_rd, cmd_ctl, cmd_rvalid, smb_alert, out_off, latched;
	logic [7:0] cmd_code, v8;
	logic [15:0] cmd_wdata, cmd_rdata, rt, v, cur;
	int error_cnt = 0;
	int n_tests = 0;
	int i, j;
	logic [7:0] cd [15] = '{`PFSB_CMD_VO_OVW, `PFSB_CMD_VO_UVW, `PFSB_CMD_VO_UVF, `PFSB_CMD_OCF, `PFSB_CMD_OCW,
		`PFSB_CMD_HOTF, `PFSB_CMD_HOTW, `PFSB_CMD_VI_OVF, `PFSB_CMD_VI_UVW, `PFSB_CMD_VI_UVF, `PFSB_CMD_VO_UVA,
		`PFSB_CMD_OCA, `PFSB_CMD_HOTA, `PFSB_CMD_VI_OVA, `PFSB_CMD_VI_UVA};
	logic [15:0] dv [15] = '{`PFSB_DEF_VO_OVW, `PFSB_DEF_VO_UVW, `PFSB_DEF_VO_UVF, `PFSB_DEF_OCF, `PFSB_DEF_OCW,
		`PFSB_DEF_HOTF, `PFSB_DEF_HOTW, `PFSB_DEF_VI_OVF, `PFSB_DEF_VI_UVW, `PFSB_DEF_VI_UVF,
		16'h00C0, 16'h00F8, 16'h00C0, 16'h00C0, 16'h00C0};
	logic [7:0] sa [5] = '{8'h80, 8'hC0, 8'h80, 8'h80, 8'h80};
	logic [7:0] sc [8] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h81};
	// Condition table: measurement, status code, expected flags; line, dropout and trip in bit masks.
	pfsb_meas_s mt [12] = '{64'h35E9_0100_08FC_0200, 64'h2A2F_0100_08FC_0200, 64'h270F_0100_08FC_0200,
		64'h270F_0100_08FC_0200, 64'h2EE0_0100_08FC_0321, 64'h2EE0_0100_08FC_0385, 64'h2EE0_0100_0AC0_0200,
		64'h2EE0_0100_0000_0200, 64'h2EE0_01C3_08FC_0200, 64'h2327_01C3_08FC_0200, 64'h2EE0_0259_08FC_0200,
		64'h2EE0_0272_08FC_0200};
	logic [7:0] ec [12] = '{8'h7A, 8'h7A, 8'h7A, 8'h7A, 8'h7D, 8'h7D, 8'h7C, 8'h7C, 8'h7B, 8'h7B, 8'h7B, 8'h7B};
	logic [7:0] ev [12] = '{8'h40, 8'h20, 8'h30, 8'h20, 8'h40, 8'hC0, 8'h80, 8'h20, 8'h80, 8'hC0, 8'h20, 8'hA0};
	logic [11:0] hl = 12'h4FF;
	logic [11:0] dr = 12'h008;
	logic [11:0] of = 12'h264;

	always #5 clk = ~clk;

	pfsb_host host (.clk_i(clk), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd), .cmd_code_o(cmd_code),
		.cmd_wdata_o(cmd_wdata), .cmd_in_control_o(cmd_ctl), .cmd_rdata_i(cmd_rdata), .cmd_rvalid_i(cmd_rvalid));
	pfsb_bank dut (.clk_i(clk), .sys_rst_i(sys_rst), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_code_i(cmd_code),
		.cmd_wdata_i(cmd_wdata), .cmd_in_control_i(cmd_ctl), .cmd_rdata_o(cmd_rdata), .cmd_rvalid_o(cmd_rvalid),
		.meas_i(meas), .hw_i(hw), .restart_done_i(restart_done), .smb_alert_o(smb_alert),
		.output_off_o(out_off), .latched_off_o(latched));

	// Stored value after a write to a one-way threshold: the input overvoltage one may only fall.
	function automatic logic [15:0] kept(input logic [7:0] c, input logic [15:0] old, input logic [15:0] nv);
		if (c == `PFSB_CMD_VI_OVF)
			kept = (nv > old) ? old : nv;
		else
			kept = (nv < old) ? old : nv;
	endfunction
	function automatic logic sel_ok(input logic [7:0] c, input logic [7:0] s);
		sel_ok = (s == `PFSB_ACT_C0) || (s == ((c == `PFSB_CMD_OCA) ? `PFSB_ACT_F8 : `PFSB_ACT_80));
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		host.rd(c, d, ok);
		chk(16'(ok), 16'h0001);
		chk(d, exp);
	endtask
	task automatic clr(input logic ctl);
		host.wr(`PFSB_CMD_CLEAR, 16'h0000, ctl);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		meas = NOM;
		hw = '0;
		hw.high_line = 1'b1;
		void'($urandom(32'h6cd2));
		rt = 16'($urandom_range(1, 255));
		mt[7].vin = 16'h0340 + rt;
		tick(2);
		sys_rst <= 1'b0;
		for (i = 0; i < 15; i++)
			rchk(cd[i], dv[i]);
		for (i = 0; i < 8; i++)
			rchk(sc[i], 16'h0000);
		for (i = 0; i < 7; i++) begin
			v = 16'($urandom);
			host.wr(cd[i], v, 1'b1);
			rchk(cd[i], v);
			host.wr(cd[i], dv[i], 1'b1);
		end
		for (i = 10; i < 15; i++) begin
			for (j = 0; j < 2; j++) begin
				v8 = j ? sa[i-10] : (8'($urandom) | 8'h01);
				host.wr(cd[i], {8'h00, v8}, 1'b1);
				rchk(cd[i], sel_ok(cd[i], v8) ? {8'h00, v8} : dv[i]);
				clr(1'b0);
				rchk(`PFSB_CMD_ST_COMM, sel_ok(cd[i], v8) ? 16'h0000 : 16'h0040);
				clr(1'b1);
			end
			host.wr(cd[i], dv[i], 1'b1);
		end
		for (i = 7; i < 10; i++) begin
			cur = dv[i];
			for (j = 0; j < 2; j++) begin
				v = j ? cur + rt : cur - rt;
				host.wr(cd[i], v, 1'b1);
				rchk(`PFSB_CMD_ST_COMM, (kept(cd[i], cur, v) === v) ? 16'h0000 : 16'h0040);
				cur = kept(cd[i], cur, v);
				rchk(cd[i], cur);
				clr(1'b1);
			end
		end
		rchk(8'h30, 16'h0000);
		rchk(`PFSB_CMD_ST_COMM, 16'h0080);
		clr(1'b1);
		host.wr(`PFSB_CMD_ST_BYTE, 16'($urandom), 1'b1);
		rchk(`PFSB_CMD_ST_COMM, 16'h0080);
		clr(1'b1);
		for (j = 0; j < 2; j++) begin
			@(posedge clk);
			hw.pec_error <= !j;
			hw.comm_fault <= j;
			@(posedge clk);
			hw.pec_error <= 1'b0;
			hw.comm_fault <= 1'b0;
			rchk(`PFSB_CMD_ST_COMM, j ? 16'h0002 : 16'h0020);
			clr(1'b1);
		end
		for (i = 0; i < 12; i++) begin
			host.gap = $urandom_range(0, 1);
			@(posedge clk);
			meas <= mt[i];
			hw.high_line <= hl[i];
			hw.vin_dropout <= dr[i];
			tick(3);
			chk(16'(smb_alert), 16'h0001);
			chk(16'(out_off), 16'(of[i]));
			rchk(ec[i], {8'h00, ev[i]});
			if (i < 2)
				rchk(`PFSB_CMD_ST_WORD, 16'h8001);
			@(posedge clk);
			meas <= NOM;
			hw.high_line <= 1'b1;
			hw.vin_dropout <= 1'b0;
			tick(3);
			rchk(ec[i], {8'h00, ev[i]});
			clr(1'b1);
			tick(3);
			chk(16'(smb_alert), 16'h0000);
			rchk(ec[i], 16'h0000);
		end
		host.wr(`PFSB_CMD_HOTA, 16'h0080, 1'b1);
		@(posedge clk);
		meas.temp <= 16'h0385;
		tick(3);
		chk(16'(latched), 16'h0001);
		@(posedge clk);
		meas <= NOM;
		tick(3);
		chk(16'(out_off), 16'h0001);
		clr(1'b1);
		@(posedge clk);
		restart_done <= 1'b1;
		@(posedge clk);
		restart_done <= 1'b0;
		tick(2);
		chk(16'(latched | out_off), 16'h0000);
		rchk(`PFSB_CMD_ST_TEMP, 16'h0000);
		host.wr(`PFSB_CMD_HOTA, 16'h00C0, 1'b1);
		@(posedge clk);
		meas.temp <= 16'h0321;
		tick(3);
		clr(1'b1);
		tick(2);
		rchk(`PFSB_CMD_ST_TEMP, 16'h0040);
		chk(16'(smb_alert), 16'h0001);
		host.wr(`PFSB_CMD_VI_UVA, 16'h0080, 1'b1);
		@(posedge clk);
		meas <= 64'h2EE0_0100_0AC0_0200;
		tick(3);
		chk({15'h0000, out_off}, 16'h0001);
		chk(16'(latched), 16'h0000);
		@(posedge clk);
		meas <= NOM;
		tick(3);
		chk(16'(out_off), 16'h0000);
		@(posedge clk);
		meas.vin <= 16'h0300;
		tick(3);
		chk(16'(latched), 16'h0001);
		report_and_stop();
	end
endmodule
